// ===== pkg/txbm_pkg.sv
package txbm_pkg;
	localparam logic [2:0] MODE_TX = 3'h4;
	localparam logic [2:0] MODE_RX = 3'h3;
	localparam int PHASE_W = 5;
	localparam int SAMP_W = 8;
	localparam logic [7:0] COARSE_RST = 8'h00;
	localparam logic [7:0] FINE_RST = 8'h00;
	localparam int FIFO_DEPTH = 16;
	// Regulator slew times in nanoseconds
	localparam int RAMP0_NS = 3000;
	localparam int RAMP1_NS = 8500;
	localparam int RAMP2_NS = 15000;
	localparam int RAMP3_NS = 23000;
	localparam int LINK_PERIOD_NS = 12;

	typedef struct packed {
		logic [SAMP_W-1:0] iSample;
		logic [SAMP_W-1:0] qSample;
	} txbm_iq_s;

	typedef struct packed {
		logic paEnable;
		logic regEnable;
		logic regGround;
		logic [1:0] rampSel;
	} txbm_pa_s;
endpackage

// ===== logic/txbm_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// FIFO: bits from the host toward the modulator
module txbm_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} txbm_fifo_s;
	txbm_fifo_s state_reg, state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full, empty;

	// Pointer compare with wrap bit
	assign empty = state_reg.wrPtr == state_reg.rdPtr;
	assign full = (state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]) && !empty;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[state_reg.rdPtr[AW-1:0]];

	// Advance pointers on handshakes
	always_comb begin
		state_next = state_reg;
		if (inValid && !full) begin
			state_next.wrPtr = state_reg.wrPtr + 1'b1;
		end
		if (outReady && !empty) begin
			state_next.rdPtr = state_reg.rdPtr + 1'b1;
		end
	end

	// Storage needs no reset
	always_ff @(posedge sys_clk) begin
		if (inValid && !full) begin
			mem[state_reg.wrPtr[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Occupancy stays within the depth; a wrap slip would show here first
	a_fifo_depth: assert property (@(posedge sys_clk) disable iff (rst)
		(AW + 1)'(state_reg.wrPtr - state_reg.rdPtr) <= (AW + 1)'(DEPTH))
		else $error("bit buffer overfilled");
	// A push offered while full must leave the write side alone
	a_fifo_refuse: assert property (@(posedge sys_clk) disable iff (rst)
		full |=> state_reg.wrPtr == $past(state_reg.wrPtr))
		else $error("push taken while full");
	// A pop offered while empty must leave the read side alone
	a_fifo_dry: assert property (@(posedge sys_clk) disable iff (rst)
		empty |=> state_reg.rdPtr == $past(state_reg.rdPtr))
		else $error("pop taken while empty");
endmodule

////////////////////////////////////////////////////////////////
// Modulator control; reference clock domain is sys_clk,
// the link-side bit clock pulses run on linkClk.
module txbm_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic [2:0] operating_mode_field,
	input wire logic ookMode,
	input wire logic [7:0] bitrate_coarse_divider,
	input wire logic [7:0] bitrate_fine_divider,
	input wire logic [7:0] deviation_divider,
	input wire logic [1:0] amplifier_ramp_select,
	input wire logic txBitIn,
	input wire logic txBitValid,
	output logic txBitReady,
	output logic bit_clock_out,
	output logic bitStrobeLink,
	output txbm_pkg::txbm_iq_s iqOut,
	output txbm_pkg::txbm_pa_s paCtrl,
	output logic txActive,
	output logic rxActive,
	output logic underrun
);
	typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} txbm_mode_e;
	typedef struct packed {
		txbm_mode_e mode;
		logic [7:0] coarseCnt;
		logic [7:0] fineCnt;
		logic [12:0] devCnt;
		logic [txbm_pkg::PHASE_W-1:0] phase;
		logic bitClk;
		logic curBit;
		logic bitToggle;
		logic underrun;
		txbm_pkg::txbm_iq_s iq;
	} txbm_core_s;
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic strobe;
	} txbm_link_s;

	txbm_core_s state_reg, state_next;
	txbm_link_s link_reg, link_next;
	logic fifoBit, fifoValid, fifoPop, bitEdge, devTick;
	logic [txbm_pkg::PHASE_W-1:0] qPhase;

	// Host bits queue here so a late host only shows as underrun
	txbm_fifo #(.WIDTH(1), .DEPTH(txbm_pkg::FIFO_DEPTH)) uFifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.inData(txBitIn),
		.inValid(txBitValid),
		.inReady(txBitReady),
		.outData(fifoBit),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	// Quarter-turn sine lookup over a 32-step cycle
	function automatic logic [txbm_pkg::SAMP_W-1:0] sineOf(input logic [txbm_pkg::PHASE_W-1:0] p);
		logic [txbm_pkg::SAMP_W-1:0] mag;
		logic [2:0] idx;
		idx = p[3] ? 3'(~p[2:0] + 3'h1) : p[2:0];
		case (idx)
			3'h0: mag = (p[3] && p[2:0] == 3'h0) ? 8'h7f : 8'h00;
			3'h1: mag = 8'h18;
			3'h2: mag = 8'h30;
			3'h3: mag = 8'h46;
			3'h4: mag = 8'h5a;
			3'h5: mag = 8'h6a;
			3'h6: mag = 8'h76;
			default: mag = 8'h7d;
		endcase
		sineOf = p[4] ? 8'(8'h80 - mag) : 8'(8'h80 + mag);
	endfunction

	// Falling edge of the half-bit clock ends a bit
	assign bitEdge = (state_reg.mode == ST_TX) && state_reg.fineCnt == 8'h00
		&& state_reg.coarseCnt == 8'h00 && state_reg.bitClk;
	assign fifoPop = bitEdge && fifoValid;
	// One phase step every 1+F reference cycles gives xtal/32/(1+F)
	assign devTick = state_reg.devCnt[7:0] == 8'h00;
	// Q leads I by a quarter turn; an FSK one bit flips the sign
	assign qPhase = (!ookMode && state_reg.curBit) ? 5'(state_reg.phase - 5'h08)
		: 5'(state_reg.phase + 5'h08);

	always_comb begin
		state_next = state_reg;
		// Mode decode
		if (operating_mode_field == txbm_pkg::MODE_TX) begin
			state_next.mode = ST_TX;
		end else if (operating_mode_field == txbm_pkg::MODE_RX) begin
			state_next.mode = ST_RX;
		end else begin
			state_next.mode = ST_IDLE;
		end
		// Cascaded reload counters then divide by two
		if (state_reg.mode != ST_TX) begin
			state_next.coarseCnt = bitrate_coarse_divider;
			state_next.fineCnt = bitrate_fine_divider;
			state_next.bitClk = 1'b0;
		end else if (state_reg.coarseCnt != 8'h00) begin
			state_next.coarseCnt = state_reg.coarseCnt - 8'h01;
		end else begin
			state_next.coarseCnt = bitrate_coarse_divider;
			if (state_reg.fineCnt != 8'h00) begin
				state_next.fineCnt = state_reg.fineCnt - 8'h01;
			end else begin
				state_next.fineCnt = bitrate_fine_divider;
				state_next.bitClk = !state_reg.bitClk;
			end
		end
		// Next bit on each bit clock event
		if (bitEdge) begin
			state_next.bitToggle = !state_reg.bitToggle;
			state_next.underrun = !fifoValid;
			if (fifoValid) begin
				state_next.curBit = fifoBit;
			end
		end
		// Phase accumulator never jumps, so I stays continuous across bit changes
		if (devTick) begin
			state_next.devCnt = {5'h00, deviation_divider};
			state_next.phase = state_reg.phase + 5'h01;
		end else begin
			state_next.devCnt = state_reg.devCnt - 13'h0001;
		end
		state_next.iq.iSample = sineOf(state_reg.phase);
		state_next.iq.qSample = sineOf(qPhase);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{mode: ST_IDLE, coarseCnt: txbm_pkg::COARSE_RST, fineCnt: txbm_pkg::FINE_RST,
				default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bit toggle crosses to the link clock; first stage feeds only the second
	// Limitation: a bit period shorter than two link cycles would lose toggles
	always_comb begin
		link_next.sync1 = state_reg.bitToggle;
		link_next.sync2 = link_reg.sync1;
		link_next.sync3 = link_reg.sync2;
		link_next.strobe = link_reg.sync2 ^ link_reg.sync3;
	end

	always_ff @(posedge linkClk or posedge rst) begin
		if (rst) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// Outputs
	assign bit_clock_out = state_reg.bitClk;
	assign bitStrobeLink = link_reg.strobe;
	assign iqOut = state_reg.iq;
	assign txActive = state_reg.mode == ST_TX;
	assign rxActive = state_reg.mode == ST_RX;
	assign underrun = state_reg.underrun;
	// OOK keys the amplifier; FSK holds it on
	assign paCtrl.paEnable = txActive && (!ookMode || state_reg.curBit);
	assign paCtrl.regEnable = txActive && (!ookMode || state_reg.curBit);
	assign paCtrl.regGround = !txActive;
	assign paCtrl.rampSel = amplifier_ramp_select;

	////////////////////////////////////////////////////////////////
	// Mode field decode shows one cycle later
	// Transmit code enters transmit
	a_tx_entry: assert property (@(posedge sys_clk) disable iff (rst)
		operating_mode_field == txbm_pkg::MODE_TX |=> txActive)
		else $error("transmit not entered");
	// Receive code enters receive
	a_rx_entry: assert property (@(posedge sys_clk) disable iff (rst)
		operating_mode_field == txbm_pkg::MODE_RX |=> rxActive)
		else $error("receive not entered");
	// Any other code leaves both paths off
	a_mode_idle: assert property (@(posedge sys_clk) disable iff (rst)
		operating_mode_field != txbm_pkg::MODE_TX && operating_mode_field != txbm_pkg::MODE_RX
		|=> !txActive && !rxActive) else $error("idle code left a path on");
	// The two paths never share the antenna pin
	a_mode_excl: assert property (@(posedge sys_clk) disable iff (rst)
		!(txActive && rxActive))
		else $error("transmit and receive together");
	// Accumulator only ever steps by one, so I never jumps
	a_phase_cont: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(state_reg.phase) |-> state_reg.phase == 5'($past(state_reg.phase) + 5'h01))
		else $error("phase jumped");
	// Each deviation tick advances the phase
	a_phase_tick: assert property (@(posedge sys_clk) disable iff (rst)
		devTick |=> state_reg.phase == 5'($past(state_reg.phase) + 5'h01))
		else $error("deviation tick lost");
	// Ticks are spaced by the reload count
	a_dev_rate: assert property (@(posedge sys_clk) disable iff (rst)
		devTick && $stable(deviation_divider) && deviation_divider != 8'h00 |=> !devTick)
		else $error("deviation step too early");
	// FSK: one puts Q a quarter turn behind I, zero a quarter ahead
	a_fsk_sign: assert property (@(posedge sys_clk) disable iff (rst)
		!ookMode |-> 5'(state_reg.phase - qPhase) == (state_reg.curBit ? 5'h08 : 5'h18))
		else $error("quadrature offset wrong");
	// OOK: the quarter-turn relation ignores the data
	a_ook_fixed: assert property (@(posedge sys_clk) disable iff (rst)
		ookMode |-> 5'(qPhase - state_reg.phase) == 5'h08)
		else $error("OOK phase relation moved");
	// A bit change never moves the accumulator by more than its own step
	a_fsk_cont: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(state_reg.curBit) |-> state_reg.phase == $past(state_reg.phase)
		|| state_reg.phase == 5'($past(state_reg.phase) + 5'h01)) else $error("phase broke at bit change");
	// OOK keys the amplifier with the bit
	a_ook_keying: assert property (@(posedge sys_clk) disable iff (rst)
		txActive && ookMode |-> paCtrl.paEnable == state_reg.curBit)
		else $error("OOK keying wrong");
	// OOK keys the regulator with the bit
	a_ook_reg: assert property (@(posedge sys_clk) disable iff (rst)
		txActive && ookMode |-> paCtrl.regEnable == state_reg.curBit)
		else $error("OOK regulator keying wrong");
	// FSK transmit holds amplifier and regulator on
	a_fsk_amp_on: assert property (@(posedge sys_clk) disable iff (rst)
		txActive && !ookMode |-> paCtrl.paEnable && paCtrl.regEnable && !paCtrl.regGround)
		else $error("amplifier off in FSK transmit");
	// Transmit never grounds the regulator output
	a_tx_no_ground: assert property (@(posedge sys_clk) disable iff (rst)
		txActive |-> !paCtrl.regGround)
		else $error("regulator grounded in transmit");
	// Receive turns the amplifier off and grounds its supply
	a_rx_amp_off: assert property (@(posedge sys_clk) disable iff (rst)
		rxActive |-> !paCtrl.paEnable && !paCtrl.regEnable && paCtrl.regGround)
		else $error("amplifier on in receive");
	// Outside transmit the regulator stays off and grounded
	a_idle_ground: assert property (@(posedge sys_clk) disable iff (rst)
		!txActive |-> paCtrl.regGround && !paCtrl.regEnable)
		else $error("regulator live outside transmit");
	// Ramp select reaches the regulator unchanged
	a_ramp_pass: assert property (@(posedge sys_clk) disable iff (rst)
		paCtrl.rampSel == amplifier_ramp_select)
		else $error("ramp select lost");
	// At most one bit taken per bit clock event
	a_one_pop: assert property (@(posedge sys_clk) disable iff (rst)
		fifoPop |=> !fifoPop)
		else $error("two bits in one bit period");
	// A taken bit drives the modulation next
	a_curbit_load: assert property (@(posedge sys_clk) disable iff (rst)
		fifoPop |=> state_reg.curBit == $past(fifoBit))
		else $error("taken bit not applied");
	// An empty buffer at a bit event raises underrun
	a_underrun_flag: assert property (@(posedge sys_clk) disable iff (rst)
		bitEdge |=> underrun == !$past(fifoValid))
		else $error("underrun flag wrong");
	// The data bit stands between bit events
	a_bit_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!bitEdge |=> $stable(state_reg.curBit))
		else $error("bit changed inside a bit period");
	// Bit clock rests low outside transmit
	a_clk_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!txActive && !$past(txActive) |-> !bit_clock_out)
		else $error("bit clock running outside transmit");
	// Counters sit at their reload values outside transmit
	a_reload: assert property (@(posedge sys_clk) disable iff (rst)
		!txActive |=> state_reg.coarseCnt == $past(bitrate_coarse_divider)
		&& state_reg.fineCnt == $past(bitrate_fine_divider)) else $error("divider not reloaded");
	// Fine counter waits for the coarse counter to run out
	a_fine_hold: assert property (@(posedge sys_clk) disable iff (rst)
		txActive && state_reg.coarseCnt != 8'h00 |=> state_reg.fineCnt == $past(state_reg.fineCnt))
		else $error("fine counter stepped early");
endmodule
`default_nettype wire

// ===== dv/txbm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Companion host: offers a bit pattern, LSB first, one bit per accept
module txbm_host_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] pattern,
	input wire logic [4:0] count,
	input wire logic go,
	input wire logic txBitReady,
	output logic txBitIn,
	output logic txBitValid
);
	logic [4:0] left;
	logic [4:0] idx;
	// Bit and valid hold until the accepting edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			left <= 5'h00;
			idx <= 5'h00;
		end else if (go) begin
			left <= count;
			idx <= 5'h00;
		end else if (txBitValid && txBitReady) begin
			left <= left - 5'h01;
			idx <= idx + 5'h01;
		end
	end
	// Idle data line shows the inverse, so a stale read cannot pass
	assign txBitValid = left != 5'h00;
	assign txBitIn = txBitValid ? pattern[idx[3:0]] : ~pattern[idx[3:0] - 4'h1];
endmodule
`default_nettype wire

// ===== dv/test_tx_baseband_modulator_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_tx_baseband_modulator_control;
	logic sys_clk = 1'b0, linkClk = 1'b0, rst = 1'b1, ookMode = 1'b0, go = 1'b0;
	logic [2:0] mode = 3'h0;
	// Index 2*Fdev/BR is exactly 2 and deviation stays put; no smoothing field here
	logic [7:0] crs = 8'h03, fin = 8'h07, dev = 8'h01;
	logic [1:0] ramp = 2'h0;
	logic [15:0] pattern = 16'h0000;
	logic [4:0] count = 5'h00;
	logic txBitIn, txBitValid, txBitReady, bitClk, strobe, txActive, rxActive, underrun;
	txbm_pkg::txbm_iq_s iq;
	txbm_pkg::txbm_pa_s pa;
	logic [6:0] rows [8] = '{7'h42, 7'h35, 7'h08, 7'h7c, 7'h50, 7'h24, 7'h68, 7'h1c};
	int n_mismatch = 0, compares = 0, cyc = 0, t, nStrobe = 0, s0;
	////////////////////////////////////////////////////////////////
	// Reference clock, and a link clock offset so edges never coincide
	always #2 sys_clk = ~sys_clk;
	initial begin
		#1.7;
		forever #6 linkClk = ~linkClk;
	end
	txbm_top txbm_top_inst (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk), .operating_mode_field(mode),
		.ookMode(ookMode), .bitrate_coarse_divider(crs), .bitrate_fine_divider(fin), .deviation_divider(dev),
		.amplifier_ramp_select(ramp), .txBitIn(txBitIn), .txBitValid(txBitValid), .txBitReady(txBitReady),
		.bit_clock_out(bitClk), .bitStrobeLink(strobe), .iqOut(iq), .paCtrl(pa), .txActive(txActive),
		.rxActive(rxActive), .underrun(underrun));
	txbm_host_model txbm_host_model_inst (.sys_clk(sys_clk), .rst(rst), .pattern(pattern), .count(count),
		.go(go), .txBitReady(txBitReady), .txBitIn(txBitIn), .txBitValid(txBitValid));
	////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Hand the host a pattern; go is a one-cycle pulse
	task automatic push(input logic [15:0] p, input logic [4:0] n);
		@(posedge sys_clk);
		pattern <= p;
		count <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	// Link-side bit events, counted in the link domain
	always @(posedge linkClk) begin
		if (strobe === 1'b1)
			nStrobe++;
	end
	// Hang guard; blocking so edge waiters see the new count
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		rst <= 1'b0;
		// Row: mode, ramp select, transmit and receive expected
		foreach (rows[i]) begin
			@(posedge sys_clk);
			mode <= rows[i][6:4];
			ramp <= rows[i][3:2];
			tick(3);
			chk("txActive", {7'h00, rows[i][1]}, {7'h00, txActive});
			chk("rxActive", {7'h00, rows[i][0]}, {7'h00, rxActive});
			chk("rampSel", {6'h00, rows[i][3:2]}, {6'h00, pa.rampSel});
			chk("paEnable", {7'h00, rows[i][1]}, {7'h00, pa.paEnable});
			chk("regEnable", {7'h00, rows[i][1]}, {7'h00, pa.regEnable});
			if (rows[i][1] | rows[i][0])
				chk("regGround", {7'h00, rows[i][0]}, {7'h00, pa.regGround});
			else
				chk("idleGround", 8'h01, {7'h00, pa.regGround});
		end
		// Bit clock period 2(1+3)(1+7), I period 32(1+1)
		@(posedge sys_clk);
		mode <= txbm_pkg::MODE_TX;
		@(posedge bitClk);
		t = cyc;
		@(posedge bitClk);
		chk("bitPeriod", 8'h40, 8'(cyc - t));
		@(posedge iq.iSample[7]);
		t = cyc;
		@(posedge iq.iSample[7]);
		chk("iqPeriod", 8'h40, 8'(cyc - t));
		// Q sign at the I upward crossing tells lag or lead
		for (int b = 1; b >= 0; b--) begin
			push({15'h0000, b[0]}, 5'h01);
			tick(140);
			@(posedge iq.iSample[7]);
			#1;
			chk("qSign", {7'h00, ~b[0]}, {7'h00, iq.qSample[7]});
		end
		// Fill while idle until refused, then send on/off keyed
		@(posedge sys_clk);
		mode <= 3'h0;
		push(16'hb2c5, 5'h10);
		tick(30);
		chk("txBitReady", 8'h00, {7'h00, txBitReady});
		@(posedge sys_clk);
		ookMode <= 1'b1;
		mode <= txbm_pkg::MODE_TX;
		s0 = nStrobe;
		for (int k = 0; k < 18; k++) begin
			@(posedge bitClk);
			#1;
			if (k > 0 && k < 17) begin
				chk("ookPa", {7'h00, pattern[k - 1]}, {7'h00, pa.paEnable});
				chk("ookReg", {7'h00, pattern[k - 1]}, {7'h00, pa.regEnable});
			end
		end
		chk("underrun", 8'h01, {7'h00, underrun});
		chk("ookHold", 8'h01, {7'h00, pa.paEnable});
		// Seventeen bit events, each seen once on the link side
		@(posedge sys_clk);
		mode <= 3'h0;
		tick(20);
		chk("strobes", 8'h11, 8'(nStrobe - s0));
		// Reset in mid transmit drops everything, release re-enters
		@(posedge sys_clk);
		mode <= txbm_pkg::MODE_TX;
		tick(4);
		rst <= 1'b1;
		tick(2);
		chk("rstTx", 8'h00, {7'h00, txActive});
		chk("rstGround", 8'h01, {7'h00, pa.regGround});
		chk("rstBitClk", 8'h00, {7'h00, bitClk});
		rst <= 1'b0;
		tick(3);
		chk("txAgain", 8'h01, {7'h00, txActive});
		conclude();
	end
endmodule
`default_nettype wire
